// ==== test/cag_addr_gen_asserts.sv ====
`timescale 1ns/10ps
module cag_addr_gen_asserts
	import cag_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire cag_req_type req,
	input wire logic req_ready,
	input wire cag_mem_type mem,
	input wire logic [PADDR_W-1:0] fetch_addr,
	input wire logic addr_error_trap,
	input wire logic stack_error_trap
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_low_direct: assert property (
		req_ready && req.op == CAG_OP_DATA && (!req.effective_address[15]
		|| (req.use_frame && req.frame_active_flag))
		|=> mem.valid && mem.addr == {8'h00, $past(req.effective_address)})
		else $error("unpaged data address wrong");
	chk_upper_paged: assert property (
		req_ready && req.op == CAG_OP_DATA && req.effective_address[15] && !req.use_frame
		|=> addr_error_trap || (mem.addr[14:0] == $past(req.effective_address[14:0])
		&& mem.addr[23:15] != 9'h000)) else $error("paged data address wrong");
	chk_fault_blocks: assert property (
		addr_error_trap || stack_error_trap |-> !mem.valid) else $error("faulted access went out");
	chk_push_unpaged: assert property (
		req_ready && req.op == CAG_OP_PUSH |=> stack_error_trap
		|| (mem.valid && mem.write && mem.addr[23:16] == 8'h00)) else $error("push address wrong");
	chk_call_words: assert property (
		req_ready && req.op == CAG_OP_CALL
		|=> (stack_error_trap || mem.wdata == $past(req.pc[15:0]))
		##1 ($past(stack_error_trap) || stack_error_trap
		|| (mem.wdata == {9'h000, $past(req.pc[22:16], 2)}
		&& mem.addr == $past(mem.addr) + 24'h000002))) else $error("call push words wrong");
	chk_exc_upper: assert property (
		req_ready && req.op == CAG_OP_EXC |=> ##1 $past(stack_error_trap) || stack_error_trap
		|| mem.wdata == {$past(req.status_low_byte, 2), 1'b0, $past(req.pc[22:16], 2)})
		else $error("exception upper word wrong");
	chk_pair_busy: assert property (
		req_ready && (req.op == CAG_OP_CALL || req.op == CAG_OP_EXC)
		|=> !req_ready || stack_error_trap)
		else $error("ready during second push word");
	chk_fetch_align: assert property (
		!$past(rst) |-> fetch_addr == {1'b0, $past(req.pc[22:1]), 1'b0})
		else $error("fetch address wrong");
	chk_table_addr: assert property (
		req_ready && req.op == CAG_OP_TABLE |=> mem.valid && mem.prog_space
		&& mem.addr[15:0] == $past(req.effective_address)) else $error("table address wrong");
	chk_window_read: assert property (
		mem.valid && mem.lsw_only |-> !mem.write && !mem.addr[0]) else $error("window misuse");
endmodule
bind cag_addr_gen cag_addr_gen_asserts chk(.core_clk, .rst, .req, .req_ready, .mem,
	.fetch_addr, .addr_error_trap, .stack_error_trap);

// ==== test/cag_core_model.sv ====
`timescale 1ns/10ps
module cag_core_model
	import cag_pkg::*;
(
	input wire logic core_clk,
	input wire logic req_ready,
	input wire cag_mem_type mem,
	output cag_req_type req
);
	cag_mem_type last;
	logic timed_out;
	initial req = '0;
	initial timed_out = 1'b0;
	// Memory side keeps only the latest access, enough for one op at a time
	always @(posedge core_clk) if (mem.valid) last <= mem;
	// An op offered while not ready is ignored, so hold it until taken
	task issue(input cag_req_type r);
		int i;
		@(posedge core_clk);
		last <= '0;
		req <= r;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (req_ready === 1'b1) break;
		end
		// An op never taken is a hang; the bench counts it
		if (i == 20) timed_out = 1'b1;
		req.op <= CAG_OP_NONE;
		repeat (3) @(posedge core_clk);
	endtask
endmodule

// ==== test/tb_cag_addr_gen.sv ====
`timescale 1ns/10ps
module tb_cag_addr_gen;
	import cag_pkg::*;
	logic core_clk, rst, cyc, stb, we, ack, irq, req_ready;
	logic [7:0] adr;
	logic [31:0] dat, rdat, q;
	logic [PADDR_W-1:0] fa;
	cag_req_type req;
	cag_mem_type mem;
	int n_mismatch, cmp_count;
	cag_addr_gen DUT(.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .req(req), .req_ready(req_ready), .mem(mem), .fetch_addr(fa),
		.addr_error_trap(), .stack_error_trap(), .irq(irq));
	cag_core_model core(.core_clk(core_clk), .req_ready(req_ready), .mem(mem), .req(req));
	task conclude;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge core_clk);
		if (i == 20) begin
			n_mismatch++;
			conclude;
		end
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task op(input cag_op_type o, input logic w, input logic f, input logic [15:0] ea,
		input logic [22:0] pc, input logic [7:0] s);
		core.issue('{o, w, f, f, ea, 16'hABCD, pc, s});
		if (core.timed_out) begin
			n_mismatch++;
			conclude;
		end
	endtask
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		{rst, cyc, stb, we, adr, dat, n_mismatch, cmp_count} = '0;
		rst = 1;
		repeat (20) @(posedge core_clk);
		rst <= 0;
		wb(0, OFF_DATA_PAGE, 0); cmp(q, 32'h1);
		wb(0, OFF_STACK_PTR, 0); cmp(q, 32'h1000);
		wb(1, OFF_DATA_PAGE, 0); wb(0, OFF_DATA_PAGE, 0); cmp(q, 32'h1);
		wb(1, OFF_DATA_PAGE, 5);
		op(CAG_OP_DATA, 1, 0, 16'h0010, 0, 0); cmp(core.last.addr, 32'h10);
		op(CAG_OP_DATA, 0, 0, 16'h8004, 0, 0); cmp(core.last.addr, 32'h028004);
		op(CAG_OP_DATA, 0, 1, 16'h9000, 0, 0); cmp(core.last.addr, 32'h9000);
		wb(1, OFF_STACK_PTR, 32'h2001); wb(0, OFF_STACK_PTR, 0); cmp(q, 32'h2000);
		op(CAG_OP_PUSH, 1, 0, 0, 0, 0); cmp(core.last.addr, 32'h2000);
		wb(0, OFF_STACK_PTR, 0); cmp(q, 32'h2002);
		op(CAG_OP_POP, 0, 0, 0, 0, 0); cmp({core.last.write, core.last.addr}, 32'h2000);
		op(CAG_OP_CALL, 1, 0, 0, 23'h7A1234, 0);
		cmp({core.last.wdata, core.last.addr[15:0]}, 32'h007A2002);
		op(CAG_OP_EXC, 1, 0, 0, 23'h7A1235, 8'hC3);
		cmp({core.last.wdata, core.last.addr[15:0]}, 32'hC37A2006);
		cmp({8'h00, fa}, 32'h007A1234);
		wb(1, OFF_TABLE_PAGE, 32'h85);
		op(CAG_OP_TABLE, 0, 0, 16'h1235, 0, 0);
		cmp({core.last.prog_space, core.last.addr}, 32'h01851235);
		op(CAG_OP_PSV, 0, 0, 16'h8003, 0, 0);
		cmp({core.last.lsw_only, core.last.addr}, 32'h01028002);
		op(CAG_OP_PSV, 1, 0, 16'h8002, 0, 0); wb(0, OFF_STATUS, 0); cmp(q, 32'h8);
		wb(1, OFF_CLEAR, 32'hC);
		wb(1, OFF_STACK_PTR, 32'hFFFE); op(CAG_OP_PUSH, 1, 0, 0, 0, 0);
		wb(0, OFF_STATUS, 0); cmp(q, 32'h4);
		cmp({31'h0, irq}, 32'h0);
		wb(1, OFF_ENABLE, 32'h4); repeat (2) @(posedge core_clk); cmp({31'h0, irq}, 32'h1);
		wb(1, OFF_CLEAR, 32'h4); repeat (2) @(posedge core_clk); cmp({31'h0, irq}, 32'h0);
		wb(0, 8'h18, 0); cmp(q, 32'h0);
		conclude;
	end
endmodule

// ==== verilog/cag_addr_gen.sv ====
`timescale 1ns/10ps

module cag_addr_gen (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire cag_pkg::cag_req_type req,
	output logic req_ready,
	output cag_pkg::cag_mem_type mem,
	output logic [cag_pkg::PADDR_W-1:0] fetch_addr,
	output logic addr_error_trap,
	output logic stack_error_trap,
	output logic irq
);
	import cag_pkg::*;

	logic [PAGE_W-1:0] data_read_page_reg;
	logic [7:0] table_page_reg;
	logic [15:0] stack_pointer_reg;
	logic [15:0] status_reg;
	logic [15:0] enable_reg;
	cag_state_type state_reg;
	logic [15:0] hi_word_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	cag_mem_type mem_reg;
	logic [PADDR_W-1:0] fetch_reg;
	logic aerr_reg;
	logic serr_reg;
	logic irq_reg;
	logic ready_reg;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr[7:2] == off[7:2]);
	endfunction

	// Bus decode; the ack goes high one cycle after the request and lasts one cycle
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_wr_hi = bus_req & wb_we_i & wb_sel_i[1];
	wire wr_page = bus_wr & hit(wb_adr_i, OFF_DATA_PAGE);
	wire wr_tbl = bus_wr & hit(wb_adr_i, OFF_TABLE_PAGE);
	wire wr_sp = bus_wr & bus_wr_hi & hit(wb_adr_i, OFF_STACK_PTR);
	wire wr_en = bus_wr & hit(wb_adr_i, OFF_ENABLE);
	wire wr_clr = bus_wr & hit(wb_adr_i, OFF_CLEAR);
	wire [PAGE_W-1:0] page_wdata = {wb_dat_i[8] & wb_sel_i[1], wb_dat_i[7:0]};
	wire page_write_ok = wr_page & (page_wdata != PAGE_ZERO);

	wire [31:0] rd_mux =
		hit(wb_adr_i, OFF_DATA_PAGE) ? {23'h000000, data_read_page_reg} :
		hit(wb_adr_i, OFF_TABLE_PAGE) ? {24'h000000, table_page_reg} :
		hit(wb_adr_i, OFF_STACK_PTR) ? {16'h0000, stack_pointer_reg} :
		hit(wb_adr_i, OFF_STATUS) ? {16'h0000, status_reg} :
		hit(wb_adr_i, OFF_ENABLE) ? {16'h0000, enable_reg} :
		32'h00000000;

	// Request decode
	wire idle = (state_reg == CAG_IDLE);
	wire take = idle & (req.op != CAG_OP_NONE);
	wire op_data = take & (req.op == CAG_OP_DATA);
	wire op_pc = take & ((req.op == CAG_OP_CALL) | (req.op == CAG_OP_EXC));
	wire op_push = take & (req.op == CAG_OP_PUSH);
	wire op_pop = take & (req.op == CAG_OP_POP);
	wire op_tbl = take & (req.op == CAG_OP_TABLE);
	wire op_psv = take & (req.op == CAG_OP_PSV);

	wire [15:0] ea = req.effective_address;
	// Frame pointer accesses stay in the base range while the frame is active
	wire unpaged = req.use_frame & req.frame_active_flag;
	wire eds_hit = ea[EA_HALF_BIT] & ~unpaged;
	wire page_zero = (data_read_page_reg == PAGE_ZERO);
	wire data_aerr = op_data & eds_hit & page_zero;
	wire psv_aerr = op_psv & (page_zero | req.write);

	wire [PADDR_W-1:0] data_addr = eds_hit ?
		{data_read_page_reg, ea[14:0]} :
		{8'h00, ea};
	wire [PADDR_W-1:0] tbl_addr = {table_page_reg, ea};
	wire [PADDR_W-1:0] psv_addr = {data_read_page_reg, ea[14:1], 1'b0};
	wire [PADDR_W-1:0] sp_addr = {8'h00, stack_pointer_reg};

	// Stack error: a push past the top of base space or a pop below zero
	wire sp_top = (stack_pointer_reg == 16'hFFFE);
	wire sp_bottom = (stack_pointer_reg == 16'h0000);
	wire push_err = (op_pc | op_push) & sp_top;
	wire hi_err = (state_reg == CAG_PUSH_HI) & sp_top;
	wire pop_err = op_pop & sp_bottom;
	wire stk_err = push_err | pop_err | hi_err;

	wire [15:0] sp_inc = stack_pointer_reg + WORD_STEP;
	wire [15:0] sp_dec = stack_pointer_reg - WORD_STEP;
	wire sp_up = ((op_pc | op_push) & ~push_err) |
		((state_reg == CAG_PUSH_HI) & ~hi_err);
	wire sp_down = op_pop & ~pop_err;
	wire [15:0] sp_core = sp_up ? sp_inc : sp_down ? sp_dec : stack_pointer_reg;
	wire [15:0] sp_sw = {wb_dat_i[15:1], 1'b0};
	// The core owns the pointer while it moves it; a bus write in that cycle is lost
	wire [15:0] stack_pointer_next = (sp_up | sp_down) ? sp_core :
		wr_sp ? sp_sw : stack_pointer_reg;

	wire [15:0] call_hi = {9'h000, req.pc[22:16]};
	wire [15:0] exc_hi = {req.status_low_byte, 1'b0, req.pc[22:16]};

	// Memory request, registered and driven on mem the next cycle
	cag_mem_type mem_next;
	always_comb begin
		mem_next = '0;
		if (state_reg == CAG_PUSH_HI) begin
			mem_next.valid = ~hi_err;
			mem_next.write = 1'b1;
			mem_next.addr = sp_addr;
			mem_next.wdata = hi_word_reg;
		end else if (op_data) begin
			mem_next.valid = ~data_aerr;
			mem_next.write = req.write;
			mem_next.addr = data_addr;
			mem_next.wdata = req.wdata;
		end else if (op_pc | op_push) begin
			mem_next.valid = ~push_err;
			mem_next.write = 1'b1;
			mem_next.addr = sp_addr;
			mem_next.wdata = op_pc ? req.pc[15:0] : req.wdata;
		end else if (op_pop) begin
			mem_next.valid = ~pop_err;
			mem_next.addr = {8'h00, sp_dec};
		end else if (op_tbl) begin
			mem_next.valid = 1'b1;
			mem_next.prog_space = 1'b1;
			mem_next.write = req.write;
			mem_next.addr = tbl_addr;
			mem_next.wdata = req.wdata;
		end else if (op_psv) begin
			mem_next.valid = ~psv_aerr;
			mem_next.prog_space = 1'b1;
			mem_next.lsw_only = 1'b1;
			mem_next.addr = psv_addr;
		end
	end

	wire cag_state_type state_next = op_pc & ~push_err ? CAG_PUSH_HI : CAG_IDLE;
	wire [15:0] evt_set = ({15'h0000, stk_err} << STK_FAULT_BIT) |
		({15'h0000, data_aerr | psv_aerr} << ADDR_ERR_BIT);
	wire [15:0] clr_bits = wr_clr ? {wb_dat_i[15:8] & {8{wb_sel_i[1]}}, wb_dat_i[7:0]} : 16'h0000;
	// A new event in the clearing cycle survives the clear
	wire [15:0] status_next = ((status_reg & ~clr_bits) | evt_set) & EVT_MASK;
	wire [15:0] enable_next = wr_en ? (wb_dat_i[15:0] & EVT_MASK) : enable_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_read_page_reg <= PAGE_RESET;
			stack_pointer_reg <= SP_RESET;
			table_page_reg <= TBLPAGE_RESET;
		end else begin
			if (page_write_ok)
				data_read_page_reg <= page_wdata;
			if (wr_tbl)
				table_page_reg <= wb_dat_i[7:0];
			stack_pointer_reg <= stack_pointer_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= CAG_IDLE;
			hi_word_reg <= 16'h0000;
			mem_reg <= '0;
			fetch_reg <= '0;
			aerr_reg <= 1'b0;
			serr_reg <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (op_pc)
				hi_word_reg <= (req.op == CAG_OP_EXC) ? exc_hi : call_hi;
			mem_reg <= mem_next;
			fetch_reg <= {1'b0, req.pc[22:1], 1'b0};
			aerr_reg <= data_aerr | psv_aerr;
			serr_reg <= stk_err;
			ready_reg <= (state_next == CAG_IDLE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_reg <= EVT_RESET;
			enable_reg <= EVT_RESET;
			irq_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			irq_reg <= |(status_next & enable_next);
			ack_reg <= bus_req;
			if (bus_req)
				rdata_reg <= wb_we_i ? 32'h00000000 : rd_mux;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign req_ready = ready_reg;
	assign mem = mem_reg;
	assign fetch_addr = fetch_reg;
	assign addr_error_trap = aerr_reg;
	assign stack_error_trap = serr_reg;
	assign irq = irq_reg;
endmodule

// ==== verilog/cag_pkg.sv ====
package cag_pkg;
	localparam int DATA_W = 16;
	localparam int PADDR_W = 24;
	localparam int PAGE_W = 9;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 9'h001;
	localparam logic [PAGE_W-1:0] PAGE_ZERO = 9'h000;
	localparam logic [15:0] SP_RESET = 16'h1000;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [7:0] TBLPAGE_RESET = 8'h00;
	localparam int EA_HALF_BIT = 15;
	localparam int CFG_PAGE_BIT = 7;

	localparam logic [7:0] OFF_DATA_PAGE = 8'h00;
	localparam logic [7:0] OFF_TABLE_PAGE = 8'h04;
	localparam logic [7:0] OFF_STACK_PTR = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_ENABLE = 8'h10;
	localparam logic [7:0] OFF_CLEAR = 8'h14;

	localparam int STK_FAULT_BIT = 2;
	localparam int ADDR_ERR_BIT = 3;
	localparam logic [15:0] EVT_MASK = 16'h000C;
	localparam logic [15:0] EVT_RESET = 16'h0000;

	typedef enum logic [2:0] {
		CAG_OP_NONE = 3'b000,
		CAG_OP_DATA = 3'b001,
		CAG_OP_CALL = 3'b010,
		CAG_OP_EXC = 3'b011,
		CAG_OP_PUSH = 3'b100,
		CAG_OP_POP = 3'b101,
		CAG_OP_TABLE = 3'b110,
		CAG_OP_PSV = 3'b111
	} cag_op_type;

	typedef enum logic {
		CAG_IDLE = 1'b0,
		CAG_PUSH_HI = 1'b1
	} cag_state_type;

	typedef struct packed {
		cag_op_type op;
		logic write;
		logic use_frame;
		logic frame_active_flag;
		logic [15:0] effective_address;
		logic [15:0] wdata;
		logic [22:0] pc;
		logic [7:0] status_low_byte;
	} cag_req_type;

	typedef struct packed {
		logic valid;
		logic prog_space;
		logic write;
		logic lsw_only;
		logic [PADDR_W-1:0] addr;
		logic [15:0] wdata;
	} cag_mem_type;
endpackage
